// ### inc/pcr_pkg.sv
// constants, types and field layout of the package idle-state resolver
// assumes one 20 MHz core clock and a synchronous active-high reset
package pcr_pkg;

	localparam logic [2:0] PCR_CS_C0 = 3'h0;
	localparam logic [2:0] PCR_CS_C1 = 3'h1;
	localparam logic [2:0] PCR_CS_C2 = 3'h2;
	localparam logic [2:0] PCR_CS_C3 = 3'h3;
	localparam logic [2:0] PCR_CS_C4 = 3'h4;
	localparam logic [2:0] PCR_CS_C6 = 3'h6;

	typedef enum logic [2:0] {
		PKG_C0  = 3'h0,
		PKG_C1  = 3'h1,
		PKG_C2  = 3'h2,
		PKG_C3  = 3'h3,
		PKG_C4  = 3'h4,
		PKG_C1E = 3'h5,
		PKG_C6  = 3'h6
	} pcr_pstate_type;

	typedef enum logic [2:0] {
		BRK_IDLE   = 3'h0,
		BRK_UNMASK = 3'h1,
		BRK_MASKED = 3'h2,
		BRK_MEM    = 3'h3,
		BRK_HOLD   = 3'h4
	} pcr_brk_state_type;

	typedef struct packed {
		logic [2:0] cstate;
		logic       c1e_hint;
	} pcr_core_req_type;

	typedef struct packed {
		logic valid;
		logic core;
		logic masked;
		logic mem;
	} pcr_brk_type;

	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} pcr_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} pcr_apb_rsp_type;

	// register offsets
	localparam logic [11:0] PCR_OFS_CTRL   = 12'h000;
	localparam logic [11:0] PCR_OFS_STATUS = 12'h004;
	localparam logic [11:0] PCR_OFS_CORES  = 12'h008;
	localparam logic [11:0] PCR_OFS_BRKCNT = 12'h00c;

	// control fields
	localparam int PCR_CTRL_C1E_EN  = 0;
	localparam int PCR_CTRL_AUTOPRO = 1;
	localparam int PCR_CTRL_LIM_LO  = 4;
	localparam logic       PCR_RST_C1E_EN  = 1'b0;
	localparam logic       PCR_RST_AUTOPRO = 1'b0;
	localparam logic [2:0] PCR_RST_LIMIT   = 3'h6;

	// status fields
	localparam int PCR_ST_PKG_LO   = 0;
	localparam int PCR_ST_PREV_LO  = 4;
	localparam int PCR_ST_BRK_LO   = 8;
	localparam int PCR_ST_GRANT    = 12;
	localparam int PCR_ST_ALLOW    = 13;
	localparam int PCR_ST_HOLD     = 14;
	localparam int PCR_ST_FREQ_LOW = 16;
	localparam int PCR_ST_VOLT_LOW = 17;
	localparam int PCR_ST_MEM_SVC  = 18;
	localparam int PCR_CORE1_LO    = 4;

	// settle time between frequency drop and voltage drop
	localparam int PCR_CLK_NS        = 50;
	localparam int PCR_VSTEP_NS      = 1000;
	localparam int PCR_VSTEP_CYC     = (PCR_VSTEP_NS + PCR_CLK_NS - 1) / PCR_CLK_NS;
	localparam logic [7:0] PCR_VSTEP = 8'(PCR_VSTEP_CYC);

endpackage

// ### design/pcr_resolver.sv
// package idle-state resolver for a two-core processor
// cores and break sources share clk; platform pins are asynchronous
`timescale 1ns/10ps
module pcr_resolver (
	input  wire logic                     clk,
	input  wire logic                     reset,
	input  wire pcr_pkg::pcr_apb_req_type apb_req,
	output pcr_pkg::pcr_apb_rsp_type      apb_rsp,
	input  wire pcr_pkg::pcr_core_req_type core_req [2],
	input  wire pcr_pkg::pcr_brk_type     brk,
	input  wire logic                     mem_done,
	input  wire logic                     cores_saved,
	input  wire logic                     llc_active,
	input  wire logic                     plat_grant,
	input  wire logic                     plat_allow,
	input  wire logic                     plat_hold,
	output logic [2:0]                    pkg_state,
	output logic [1:0]                    core_wake,
	output logic                          brk_msg_valid,
	output logic                          brk_msg_core,
	output logic                          mem_service,
	output logic                          freq_low,
	output logic                          volt_low,
	output logic                          llc_snoop_en,
	output logic                          regulator_deep_sleep_flag,
	output logic                          regulator_load_hint
);
	import pcr_pkg::*;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	function automatic logic [2:0] shallower(input logic [2:0] a, input logic [2:0] b);
		shallower = (a < b) ? a : b;
	endfunction

	function automatic logic is_reg(input logic [11:0] a, input logic [11:0] ofs);
		is_reg = (a == ofs);
	endfunction

	// ---------------------------------------------------------------
	// platform pin synchronisers
	// ---------------------------------------------------------------
	logic [2:0] plat_meta_r;
	logic [2:0] plat_sync_r;
	logic       grant_s;
	logic       allow_s;
	logic       hold_s;

	always_ff @(posedge clk) begin
		if (reset) begin
			plat_meta_r <= 3'h0;
			plat_sync_r <= 3'h0;
		end else begin
			plat_meta_r <= {plat_hold, plat_allow, plat_grant};
			plat_sync_r <= plat_meta_r;
		end
	end

	assign grant_s = plat_sync_r[0];
	assign allow_s = plat_sync_r[1];
	assign hold_s  = plat_sync_r[2];

	// ---------------------------------------------------------------
	// control register
	// ---------------------------------------------------------------
	logic       c1e_en_r;
	logic       autopro_r;
	logic [2:0] limit_r;
	logic       wr_acc;
	logic       rd_setup;

	assign wr_acc   = apb_req.psel & apb_req.penable & apb_req.pwrite;
	assign rd_setup = apb_req.psel & ~apb_req.penable & ~apb_req.pwrite;

	always_ff @(posedge clk) begin
		if (reset) begin
			c1e_en_r  <= PCR_RST_C1E_EN;
			autopro_r <= PCR_RST_AUTOPRO;
			limit_r   <= PCR_RST_LIMIT;
		end else if (wr_acc && is_reg(apb_req.paddr, PCR_OFS_CTRL)) begin
			c1e_en_r  <= apb_req.pwdata[PCR_CTRL_C1E_EN];
			autopro_r <= apb_req.pwdata[PCR_CTRL_AUTOPRO];
			limit_r   <= apb_req.pwdata[PCR_CTRL_LIM_LO +: 3];
		end
	end

	// ---------------------------------------------------------------
	// resolution of the requested package state
	// ---------------------------------------------------------------
	logic [2:0]     req_min;
	logic           all_hint;
	pcr_pstate_type c1_kind;
	pcr_pstate_type target;

	assign req_min  = shallower(core_req[0].cstate, core_req[1].cstate);
	assign all_hint = core_req[0].c1e_hint & core_req[1].c1e_hint;

	// plain C1 saves nothing; hint or auto-promotion lifts it to C1E
	always_comb begin
		c1_kind = PKG_C1;
		if (c1e_en_r && (all_hint || autopro_r)) begin
			c1_kind = PKG_C1E;
		end
	end

	// cores are never forced shallower here, so they may sit deeper
	always_comb begin
		target = PKG_C0;
		if (req_min == PCR_CS_C0) begin
			target = PKG_C0;
		end else if (req_min == PCR_CS_C1) begin
			target = c1_kind;
		end else if (limit_r <= PCR_CS_C1) begin
			target = c1e_en_r ? PKG_C1E : PKG_C1;
		end else if (req_min == PCR_CS_C6 && !grant_s && allow_s) begin
			target = PKG_C3;
		end else if (!grant_s) begin
			target = PKG_C0;
		end else begin
			case (shallower(req_min, limit_r))
				PCR_CS_C2: target = PKG_C2;
				PCR_CS_C3: target = PKG_C3;
				PCR_CS_C4: target = PKG_C4;
				PCR_CS_C6: target = cores_saved ? PKG_C6 : PKG_C4;
				default:   target = PKG_C4;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// break handling and package state
	// ---------------------------------------------------------------
	pcr_brk_state_type brk_r;
	pcr_pstate_type    pkg_r;
	pcr_pstate_type    prev_r;
	logic              tgt_r;
	logic              mem_svc_r;
	logic [1:0]        wake_r;
	logic              msg_valid_r;
	logic              msg_core_r;
	logic [15:0]       brk_cnt_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			brk_r  <= BRK_IDLE;
			pkg_r  <= PKG_C0;
			prev_r <= PKG_C0;
			tgt_r  <= 1'b0;
		end else begin
			case (brk_r)
				BRK_IDLE: begin
					if (brk.valid) begin
						prev_r <= pkg_r;
						tgt_r  <= brk.core;
						pkg_r  <= PKG_C0;
						if (brk.mem) begin
							brk_r <= hold_s ? BRK_HOLD : BRK_MEM;
						end else if (brk.masked) begin
							brk_r <= BRK_MASKED;
						end else begin
							brk_r <= BRK_UNMASK;
						end
					end else if (pkg_r == PKG_C6 && llc_active && target != PKG_C0) begin
						pkg_r <= PKG_C6;
					end else begin
						pkg_r <= target;
					end
				end
				BRK_UNMASK: begin
					// package waits in C0 until the woken core reports C0
					pkg_r <= PKG_C0;
					if (core_req[tgt_r].cstate == PCR_CS_C0) begin
						brk_r <= BRK_IDLE;
					end
				end
				BRK_MASKED: begin
					pkg_r <= prev_r;
					brk_r <= BRK_IDLE;
				end
				BRK_MEM: begin
					if (mem_done) begin
						pkg_r <= prev_r;
						brk_r <= BRK_IDLE;
					end
				end
				BRK_HOLD: begin
					pkg_r <= PKG_C0;
					if (mem_done && !hold_s) begin
						brk_r <= BRK_IDLE;
					end
				end
				default: begin
					brk_r <= BRK_IDLE;
				end
			endcase
		end
	end

	// memory service flag covers both memory break paths
	always_ff @(posedge clk) begin
		if (reset) begin
			mem_svc_r <= 1'b0;
		end else if (brk_r == BRK_IDLE && brk.valid && brk.mem) begin
			mem_svc_r <= 1'b1;
		end else if (mem_done) begin
			mem_svc_r <= 1'b0;
		end
	end

	// core wake and message forwarding, one-cycle pulses
	always_ff @(posedge clk) begin
		if (reset) begin
			wake_r      <= 2'h0;
			msg_valid_r <= 1'b0;
			msg_core_r  <= 1'b0;
		end else begin
			wake_r      <= 2'h0;
			msg_valid_r <= 1'b0;
			if (brk_r == BRK_IDLE && brk.valid && !brk.mem) begin
				wake_r[brk.core] <= 1'b1;
				msg_valid_r      <= 1'b1;
				msg_core_r       <= brk.core;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			brk_cnt_r <= 16'h0000;
		end else if (brk_r == BRK_IDLE && brk.valid) begin
			brk_cnt_r <= brk_cnt_r + 16'h0001;
		end
	end

	// ---------------------------------------------------------------
	// C1E frequency then voltage sequencing
	// ---------------------------------------------------------------
	logic       freq_low_r;
	logic       volt_low_r;
	logic [7:0] vstep_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			freq_low_r <= 1'b0;
			volt_low_r <= 1'b0;
			vstep_r    <= 8'h00;
		end else if (pkg_r == PKG_C1E) begin
			if (!freq_low_r) begin
				freq_low_r <= 1'b1;
				vstep_r    <= PCR_VSTEP;
			end else if (vstep_r != 8'h00) begin
				vstep_r <= vstep_r - 8'h01;
			end else begin
				volt_low_r <= 1'b1;
			end
		end else begin
			// raise voltage before restoring the clock
			volt_low_r <= 1'b0;
			if (!volt_low_r) begin
				freq_low_r <= 1'b0;
			end
			vstep_r <= 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// regulator and cache indicators
	// ---------------------------------------------------------------
	logic deep_r;
	logic load_r;
	logic snoop_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			deep_r  <= 1'b0;
			load_r  <= 1'b0;
			snoop_r <= 1'b1;
		end else begin
			deep_r  <= (pkg_r == PKG_C6);
			load_r  <= (pkg_r != PKG_C0);
			snoop_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// apb read path, zero wait states
	// ---------------------------------------------------------------
	logic [31:0] rdata_r;
	logic        rd_err_r;
	logic        map_hit;

	assign map_hit = is_reg(apb_req.paddr, PCR_OFS_CTRL) | is_reg(apb_req.paddr, PCR_OFS_STATUS) |
		is_reg(apb_req.paddr, PCR_OFS_CORES) | is_reg(apb_req.paddr, PCR_OFS_BRKCNT);

	always_ff @(posedge clk) begin
		if (reset) begin
			rdata_r  <= 32'h0000_0000;
			rd_err_r <= 1'b0;
		end else if (apb_req.psel && !apb_req.penable) begin
			rdata_r  <= 32'h0000_0000;
			rd_err_r <= ~map_hit;
			if (rd_setup) begin
				case (apb_req.paddr)
					PCR_OFS_CTRL: begin
						rdata_r[PCR_CTRL_C1E_EN]         <= c1e_en_r;
						rdata_r[PCR_CTRL_AUTOPRO]        <= autopro_r;
						rdata_r[PCR_CTRL_LIM_LO +: 3]    <= limit_r;
					end
					PCR_OFS_STATUS: begin
						rdata_r[PCR_ST_PKG_LO +: 3]      <= pkg_r;
						rdata_r[PCR_ST_PREV_LO +: 3]     <= prev_r;
						rdata_r[PCR_ST_BRK_LO +: 3]      <= brk_r;
						rdata_r[PCR_ST_GRANT]            <= grant_s;
						rdata_r[PCR_ST_ALLOW]            <= allow_s;
						rdata_r[PCR_ST_HOLD]             <= hold_s;
						rdata_r[PCR_ST_FREQ_LOW]         <= freq_low_r;
						rdata_r[PCR_ST_VOLT_LOW]         <= volt_low_r;
						rdata_r[PCR_ST_MEM_SVC]          <= mem_svc_r;
					end
					PCR_OFS_CORES: begin
						rdata_r[2:0]                     <= core_req[0].cstate;
						rdata_r[PCR_CORE1_LO +: 3]       <= core_req[1].cstate;
					end
					PCR_OFS_BRKCNT: begin
						rdata_r[15:0]                    <= brk_cnt_r;
					end
					default: begin
						rdata_r <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	assign apb_rsp.pready  = 1'b1;
	assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & rd_err_r;
	assign apb_rsp.prdata  = rdata_r;

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign pkg_state                 = pkg_r;
	assign core_wake                 = wake_r;
	assign brk_msg_valid             = msg_valid_r;
	assign brk_msg_core              = msg_core_r;
	assign mem_service               = mem_svc_r;
	assign freq_low                  = freq_low_r;
	assign volt_low                  = volt_low_r;
	assign llc_snoop_en              = snoop_r;
	assign regulator_deep_sleep_flag = deep_r;
	assign regulator_load_hint       = load_r;

endmodule

// ### tb/pcr_checker.sv
// assertions on the idle-state resolver ports
// bound into pcr_resolver; one clock, sync reset
`timescale 1ns/10ps
module pcr_checker (
	input wire logic                      clk,
	input wire logic                      reset,
	input wire pcr_pkg::pcr_core_req_type core_req [2],
	input wire logic                      cores_saved,
	input wire logic [2:0]                pkg_state,
	input wire logic [1:0]                core_wake,
	input wire logic                      brk_msg_valid,
	input wire logic                      brk_msg_core,
	input wire logic                      freq_low,
	input wire logic                      volt_low,
	input wire logic                      llc_snoop_en,
	input wire logic                      regulator_deep_sleep_flag
);
	import pcr_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// ----
	// assertions
	// ----
	deep_flag_a:
		assert property (regulator_deep_sleep_flag == ($past(pkg_state) == PKG_C6))
		else $error("deep-sleep flag out of step");
	snoop_on_a:
		assert property (pkg_state == PKG_C3 |-> llc_snoop_en)
		else $error("cache not snoopable");
	wake_target_a:
		assert property (brk_msg_valid |-> core_wake == (2'h1 << brk_msg_core))
		else $error("wake not on target core");
	break_pkg_c0_a:
		assert property (brk_msg_valid |-> pkg_state == PKG_C0)
		else $error("package not C0 on break");
	volt_after_freq_a:
		assert property ($rose(volt_low) |-> freq_low && $past(freq_low, 20))
		else $error("voltage dropped early");
	c1_plain_a:
		assert property (pkg_state == PKG_C1 [*4] |-> !freq_low && !volt_low)
		else $error("extra saving in C1");
	core_active_a:
		assert property (core_req[0].cstate == 3'h0 || core_req[1].cstate == 3'h0 |=> pkg_state == PKG_C0)
		else $error("package idle with core active");
	c6_saved_a:
		assert property ($changed(pkg_state) && pkg_state == PKG_C6 |-> $past(cores_saved))
		else $error("C6 without saved cores");
	cover property (pkg_state == PKG_C6);
	cover property ($rose(volt_low));
	cover property (brk_msg_valid);
endmodule

bind pcr_resolver pcr_checker i_chk (
	.clk                       (clk),
	.reset                     (reset),
	.core_req                  (core_req),
	.cores_saved               (cores_saved),
	.pkg_state                 (pkg_state),
	.core_wake                 (core_wake),
	.brk_msg_valid             (brk_msg_valid),
	.brk_msg_core              (brk_msg_core),
	.freq_low                  (freq_low),
	.volt_low                  (volt_low),
	.llc_snoop_en              (llc_snoop_en),
	.regulator_deep_sleep_flag (regulator_deep_sleep_flag)
);

// ### tb/pcr_platform_model.sv
// platform side: drives the permission and hold pins
// bench sets the wanted levels; slow adds settle cycles
`timescale 1ns/10ps
module pcr_platform_model (
	input  wire logic clk,
	input  wire logic reset,
	input  wire logic grant_req,
	input  wire logic allow_req,
	input  wire logic hold_req,
	input  wire logic slow,
	output logic      plat_grant,
	output logic      plat_allow,
	output logic      plat_hold
);
	logic [1:0] wait_r;
	// pins move together so grant never leads allow
	always_ff @(posedge clk) begin
		if (reset) begin
			{plat_grant, plat_allow, plat_hold} <= 3'h0;
			wait_r <= 2'h0;
		end else if ({grant_req, allow_req, hold_req} != {plat_grant, plat_allow, plat_hold}) begin
			if (!slow || wait_r == 2'h3) begin
				{plat_grant, plat_allow, plat_hold} <= {grant_req, allow_req, hold_req};
				wait_r <= 2'h0;
			end else begin
				wait_r <= wait_r + 2'h1;
			end
		end
	end
endmodule

// ### tb/tb_top.sv
// self-checking bench for the idle-state resolver
// drives apb, core requests and breaks; platform model on the pins
`timescale 1ns/10ps
module tb_top;
	import pcr_pkg::*;
	logic             clk, reset, mem_done, cores_saved, llc_active;
	logic             grant_req, allow_req, hold_req, slow;
	logic             plat_grant, plat_allow, plat_hold;
	pcr_apb_req_type  apb_req;
	pcr_apb_rsp_type  apb_rsp;
	pcr_core_req_type core_req [2];
	pcr_brk_type      brk;
	logic [2:0]       pkg_state;
	logic [1:0]       core_wake;
	logic             brk_msg_valid, brk_msg_core, mem_service, freq_low, volt_low;
	logic             llc_snoop_en, regulator_deep_sleep_flag, regulator_load_hint;
	logic [31:0]      q;
	logic             e;
	logic [3:0]       seen_brk;
	int               n_fail, check_count;
	localparam logic [2:0]  CS [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h6};
	localparam logic [31:0] CT [4] = '{32'h60, 32'h61, 32'h63, 32'h11};
	localparam logic [2:0]  CC [4] = '{3'h1, 3'h1, 3'h1, 3'h4};
	localparam logic [2:0]  EX [4] = '{3'h1, 3'h5, 3'h5, 3'h5};
	localparam logic [3:0]  HH     = 4'h3;

	pcr_resolver i_dut (.clk(clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
		.core_req(core_req), .brk(brk), .mem_done(mem_done), .cores_saved(cores_saved),
		.llc_active(llc_active), .plat_grant(plat_grant), .plat_allow(plat_allow),
		.plat_hold(plat_hold), .pkg_state(pkg_state), .core_wake(core_wake),
		.brk_msg_valid(brk_msg_valid), .brk_msg_core(brk_msg_core), .mem_service(mem_service),
		.freq_low(freq_low), .volt_low(volt_low), .llc_snoop_en(llc_snoop_en),
		.regulator_deep_sleep_flag(regulator_deep_sleep_flag),
		.regulator_load_hint(regulator_load_hint));
	pcr_platform_model i_plat (.clk(clk), .reset(reset), .grant_req(grant_req),
		.allow_req(allow_req), .hold_req(hold_req), .slow(slow), .plat_grant(plat_grant),
		.plat_allow(plat_allow), .plat_hold(plat_hold));

	// ----
	// tasks
	// ----
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	// hold the request until pready is seen; one idle cycle after release
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		apb_req <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		apb_req.penable <= 1'b1;
		// no timeout in the loop; only the watchdog ends a wait that never sees pready
		do begin
			@(posedge clk);
		end while (apb_rsp.pready !== 1'b1);
		q = apb_rsp.prdata;
		e = apb_rsp.pslverr;
		apb_req <= '0;
		@(posedge clk);
	endtask
	task cores(input logic [2:0] c0, input logic [2:0] c1, input logic h);
		core_req[0] <= '{c0, h};
		core_req[1] <= '{c1, h};
		@(posedge clk);
	endtask
	task plat(input logic g, input logic a, input logic h);
		grant_req <= g;
		allow_req <= a;
		hold_req <= h;
		cyc(12);
	endtask
	task pulse(input pcr_brk_type b);
		brk <= b;
		@(posedge clk);
		brk <= '0;
		// wake and message pulses stand for one cycle; look mid-cycle
		@(negedge clk);
		seen_brk = {brk_msg_valid, brk_msg_core, core_wake};
		cyc(4);
	endtask
	task end_sim;
		$display("checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		end_sim;
	end
	initial begin
		{reset, cores_saved, grant_req, allow_req} = 4'hf;
		{mem_done, llc_active, hold_req, slow} = 4'h0;
		apb_req = '0;
		core_req[0] = '0;
		core_req[1] = '0;
		brk = '0;
		n_fail = 0;
		check_count = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		apb(1'b0, 12'h000, 32'h0);
		chk(q, 32'h60);
		apb(1'b0, 12'h010, 32'h0);
		chk(32'(e), 32'h1);
		cyc(8);
		for (int i = 0; i < 6; i++)
			for (int j = 0; j < 6; j++) begin
				cores(CS[i], CS[j], 1'b0);
				cyc(3);
				chk(32'(pkg_state), 32'((CS[i] < CS[j]) ? CS[i] : CS[j]));
			end
		$display("resolution table done");
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 12'h000, CT[k]);
			cores(CC[k], CC[k], HH[k]);
			cyc(24);
			chk(32'(pkg_state), 32'(EX[k]));
			chk(32'(volt_low), 32'(EX[k] == 3'h5));
			cores(3'h0, 3'h0, 1'b0);
			cyc(4);
		end
		apb(1'b1, 12'h000, 32'h60);
		$display("c1e test done");
		cores(3'h6, 3'h6, 1'b0);
		plat(1'b0, 1'b1, 1'b0);
		chk(32'(pkg_state), 32'h3);
		plat(1'b1, 1'b1, 1'b0);
		chk(32'(regulator_deep_sleep_flag), 32'h1);
		llc_active <= 1'b1;
		cores(3'h3, 3'h3, 1'b0);
		cyc(4);
		chk(32'(pkg_state), 32'h6);
		llc_active <= 1'b0;
		cyc(4);
		chk(32'(pkg_state), 32'h3);
		plat(1'b0, 1'b0, 1'b0);
		chk(32'(pkg_state), 32'h0);
		plat(1'b1, 1'b1, 1'b0);
		chk(32'(regulator_load_hint), 32'h1);
		$display("platform test done");
		pulse('{1'b1, 1'b0, 1'b1, 1'b0});
		chk(32'(seen_brk), 32'h9);
		chk(32'(pkg_state), 32'h3);
		pulse('{1'b1, 1'b1, 1'b0, 1'b0});
		chk(32'(seen_brk), 32'he);
		chk(32'(pkg_state), 32'h0);
		cores(3'h3, 3'h0, 1'b0);
		cores(3'h3, 3'h3, 1'b0);
		cyc(4);
		chk(32'(pkg_state), 32'h3);
		pulse('{1'b1, 1'b0, 1'b0, 1'b1});
		chk(32'({seen_brk[3], seen_brk[1:0]}), 32'h0);
		chk(32'(mem_service), 32'h1);
		mem_done <= 1'b1;
		cyc(4);
		mem_done <= 1'b0;
		chk(32'(pkg_state), 32'h3);
		slow <= 1'b1;
		plat(1'b1, 1'b1, 1'b1);
		pulse('{1'b1, 1'b0, 1'b0, 1'b1});
		mem_done <= 1'b1;
		cyc(6);
		chk(32'(pkg_state), 32'h0);
		plat(1'b1, 1'b1, 1'b0);
		mem_done <= 1'b0;
		chk(32'(pkg_state), 32'h3);
		apb(1'b0, PCR_OFS_BRKCNT, 32'h0);
		chk(q, 32'h4);
		$display("break test done");
		end_sim;
	end
endmodule
